//--- core/frich_ctrl.sv
// Fast-register input chain controller for the instruction in the second instruction register
`timescale 1ns/1ns
module frich_ctrl
  import frich_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire frich_ctl_t        ctl,
  input  wire logic [ADDR_W-1:0] secondInstrA,
  input  wire logic [ADDR_W-1:0] secondInstrM,
  input  wire logic [ADDR_W-1:0] adderOut,
  input  wire logic              generalMemoryRead,
  input  wire logic              memNotBusy,
  input  wire logic              aConflict,
  input  wire logic              mConflict,
  input  wire logic [WORD_W-1:0] frReadData,
  output logic [2:0]             phase_reg,
  output frich_strb_t            strobe_reg,
  output logic [ADDR_W-1:0]      adderInA_reg,
  output logic [ADDR_W-1:0]      adderInB_reg,
  output logic [SEL_W-1:0]       selector_reg,
  output logic [WORD_W-1:0]      aInput_reg,
  output logic [WORD_W-1:0]      mInput_reg,
  output logic [WORD_W-1:0]      frWriteData_reg,
  output logic                   operandAck_reg,
  output logic                   aChainStart_reg,
  output logic                   mChainStart_reg,
  output logic                   frRead_reg
);

  // ****************************************************************
  // Phase timing
  // ****************************************************************
  logic [2:0] phase;
  logic       phaseStrobe;

  frich_phase_gen frich_phase_gen_i (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .phase       (phase),
    .phaseStrobe (phaseStrobe)
  );

  // Phase decode used throughout
  function automatic logic atPhase(input logic [2:0] p, input logic [2:0] want);
    return p == want;
  endfunction

  logic aChainInequality_reg;
  logic aChainEquality_reg;
  logic mChainInequality_reg;
  logic mChainEquality_reg;
  logic aChainReadEnable;
  logic mChainTransferEnable;
  logic frDetect;
  logic pT0, pT2, pT3, pT4, pT5, pT6, pT7;

  assign pT0 = phaseStrobe && atPhase(phase, PH_T0);
  assign pT2 = phaseStrobe && atPhase(phase, PH_T2);
  assign pT3 = phaseStrobe && atPhase(phase, PH_T3);
  assign pT4 = phaseStrobe && atPhase(phase, PH_T4);
  assign pT5 = phaseStrobe && atPhase(phase, PH_T5);
  assign pT6 = phaseStrobe && atPhase(phase, PH_T6);
  assign pT7 = phaseStrobe && atPhase(phase, PH_T7);

  // Top three digits 999 mark a fast register
  assign frDetect = (adderOut[ADDR_W-1:SEL_W] == FR_PREFIX);
  assign aChainReadEnable     = aChainInequality_reg && !aChainEquality_reg;
  assign mChainTransferEnable = mChainInequality_reg && !mChainEquality_reg;

  // Phase mirror for the outside
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      phase_reg <= PH_T0;
    end else begin
      phase_reg <= phase;
    end
  end

  // ****************************************************************
  // Address adder operands
  // ****************************************************************
  // A field plus zero or a double-precision offset, formed at t2
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      adderInA_reg <= '0;
      adderInB_reg <= '0;
    end else if (pT2 && ctl.aAddrGate) begin
      adderInA_reg <= secondInstrA;
      if (ctl.zeroSel) begin
        adderInB_reg <= '0;
      end else if (ctl.dpCond) begin
        adderInB_reg <= ADDR_W'({ctl.dpCondAdd});
      end else begin
        adderInB_reg <= ADDR_W'(ctl.dpOffset);
      end
    end
  end

  // ****************************************************************
  // Chain start and acknowledge flip-flops
  // ****************************************************************
  // A start: request with ack, or double-precision conditional without ack
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      aChainStart_reg <= 1'b0;
    end else if ((ctl.aChainReq && operandAck_reg) ||
                 (ctl.dpCond && !operandAck_reg)) begin
      aChainStart_reg <= 1'b1;
    end else if (pT0) begin
      aChainStart_reg <= 1'b0;
    end
  end

  // Read flop set at t7 on detect plus memory read, cleared after t0 use
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      frRead_reg <= 1'b0;
    end else if (pT7 && frDetect && generalMemoryRead) begin
      frRead_reg <= 1'b1;
    end else if (pT0) begin
      frRead_reg <= 1'b0;
    end
  end

  // Acknowledge: true memory-not-busy or simulated by the read flop; cleared at t7 when neither source is present
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      operandAck_reg <= 1'b0;
    end else if (memNotBusy || frRead_reg) begin
      operandAck_reg <= 1'b1;
    end else if (pT7) begin
      operandAck_reg <= 1'b0;
    end
  end

  // M start: from the read flop at t0 or direct A-through-M instructions
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mChainStart_reg <= 1'b0;
    end else if ((pT0 && frRead_reg) || ctl.mChainDirect) begin
      mChainStart_reg <= 1'b1;
    end else if (pT4) begin
      mChainStart_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Conflict flip-flops
  // ****************************************************************
  // A chain: equality or inequality set at t6; cleared after the t0 check
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      aChainInequality_reg <= 1'b0;
      aChainEquality_reg   <= 1'b0;
    end else if (pT6 && aChainStart_reg) begin
      aChainInequality_reg <= !aConflict;
      aChainEquality_reg   <= aConflict;
    end else if (pT0) begin
      aChainInequality_reg <= 1'b0;
      aChainEquality_reg   <= 1'b0;
    end
  end

  // M chain: set at t2, holds through t0 of the next cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mChainInequality_reg <= 1'b0;
      mChainEquality_reg   <= 1'b0;
    end else if (pT2 && mChainStart_reg) begin
      mChainInequality_reg <= !mConflict;
      mChainEquality_reg   <= mConflict;
    end else if (pT0) begin
      mChainInequality_reg <= 1'b0;
      mChainEquality_reg   <= 1'b0;
    end
  end

  // ****************************************************************
  // Selector register
  // ****************************************************************
  // t0 sources have priority by listed order; t4 loads the A address
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      selector_reg <= FR_INDEX_ZERO;
    end else if (pT0 && frRead_reg) begin
      selector_reg <= secondInstrM[SEL_W-1:0];
    end else if (pT0 && ctl.aDirectSel) begin
      selector_reg <= secondInstrA[SEL_W-1:0];
    end else if (pT0 && ctl.adderSel) begin
      selector_reg <= adderOut[SEL_W-1:0];
    end else if (pT4 && aChainStart_reg) begin
      selector_reg <= adderOut[SEL_W-1:0];
    end
  end

  // ****************************************************************
  // Function strobes
  // ****************************************************************
  // One-clock strobes aligned to the phase end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      strobe_reg <= '0;
    end else begin
      strobe_reg.aFieldToAdder   <= pT2 && ctl.aAddrGate;
      strobe_reg.zerosToAdder    <= pT2 && ctl.aAddrGate && ctl.zeroSel;
      strobe_reg.adderToSelector <= (pT4 && aChainStart_reg) || (pT0 && ctl.adderSel);
      strobe_reg.encoderToAu     <= pT5 && ctl.auInfoReq && operandAck_reg;
      strobe_reg.frRegenerate    <= (pT7 && aChainStart_reg) ||
                                    (pT3 && mChainStart_reg);
      strobe_reg.frReadout       <= (pT7 && aChainReadEnable) ||
                                    (pT3 && mChainStart_reg && !atPhase(phase, PH_T7));
      strobe_reg.parityCheckStart <= (pT0 && aChainInequality_reg) ||
                                     (pT4 && mChainInequality_reg && operandAck_reg);
      strobe_reg.mLowDigitsToSelector   <= pT0 && frRead_reg;
      strobe_reg.aFieldDirectToSelector <= pT0 && ctl.aDirectSel;
      strobe_reg.regenToMInput <= pT4 && mChainTransferEnable && operandAck_reg;
    end
  end

  // ****************************************************************
  // Data paths
  // ****************************************************************
  // Readout to A input and rewrite: a destructive read must be restored at once
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      aInput_reg      <= '0;
      frWriteData_reg <= '0;
    end else if ((pT7 && aChainReadEnable) || (pT3 && mChainStart_reg)) begin
      aInput_reg      <= frReadData;
      frWriteData_reg <= frReadData;
    end
  end

  // M input register keeps the operand until replaced
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mInput_reg <= '0;
    end else if (pT4 && mChainTransferEnable && operandAck_reg) begin
      mInput_reg <= frWriteData_reg;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Named steps: A readout at t7, and the M read flop followed by its simulated ack
  sequence s_readAtT7;
    pT7 && aChainReadEnable;
  endsequence

  sequence s_frReadSet;
    pT7 && frDetect && generalMemoryRead;
  endsequence

  sequence s_readThenAck;
    frRead_reg ##1 operandAck_reg;
  endsequence

  // Each check sits one clock after the phase edge or request that launches the action, except the simulated ack, checked two clocks after the read-flop set
  a_phase_wrap: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pT7 |=> phase == PH_T0) else $error("phase did not wrap");
  a_achain_start: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ((ctl.aChainReq && operandAck_reg) || (ctl.dpCond && !operandAck_reg)) |=> aChainStart_reg)
    else $error("A start not set");
  a_sel_load_t4: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pT4 && aChainStart_reg && !pT0) |=> selector_reg == $past(adderOut[SEL_W-1:0]))
    else $error("selector not loaded at t4");
  a_readout_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_readAtT7 |=> strobe_reg.frReadout && strobe_reg.frRegenerate)
    else $error("A readout missing");
  a_parity_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pT0 && aChainInequality_reg) |=> strobe_reg.parityCheckStart)
    else $error("A parity missing");
  a_fr_read_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_frReadSet |=> s_readThenAck)
    else $error("read flop or ack missing");
  a_sel_m_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pT0 && frRead_reg) |=> selector_reg == $past(secondInstrM[SEL_W-1:0]))
    else $error("M low digits not loaded");
  a_m_start: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pT0 && frRead_reg) |=> mChainStart_reg) else $error("M start missing");
  a_m_transfer: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pT4 && mChainTransferEnable && operandAck_reg) |=> strobe_reg.regenToMInput
    && mInput_reg == $past(frWriteData_reg)) else $error("M transfer missing");
  a_m_parity: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pT4 && mChainInequality_reg && operandAck_reg) |=> strobe_reg.parityCheckStart)
    else $error("M parity missing");
  a_encoder_au: assert property (@(posedge clk_sys) disable iff (sys_rst)
    strobe_reg.encoderToAu |-> $past(operandAck_reg) && $past(phase) == PH_T5)
    else $error("encoder strobe wrong");

endmodule

//--- core/frich_pkg.sv
// Package for the fast-register input chain controller: phases, widths, field layouts
package frich_pkg;

  // Eight pulse phases t0..t7 per 4 us cycle
  localparam int          PHASE_COUNT   = 8;
  localparam logic [2:0]  PH_T0         = 3'h0;
  localparam logic [2:0]  PH_T2         = 3'h2;
  localparam logic [2:0]  PH_T3         = 3'h3;
  localparam logic [2:0]  PH_T4         = 3'h4;
  localparam logic [2:0]  PH_T5         = 3'h5;
  localparam logic [2:0]  PH_T6         = 3'h6;
  localparam logic [2:0]  PH_T7         = 3'h7;

  // Cycle timing: 4 us instruction period at 100 MHz
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          CYCLE_TIME_NS = 4000;
  localparam int          PHASE_TIME_NS = CYCLE_TIME_NS / PHASE_COUNT;
  localparam int          PHASE_CLKS    = PHASE_TIME_NS / CLK_PERIOD_NS;
  localparam logic [5:0]  PHASE_LAST    = 6'(PHASE_CLKS - 1);

  // Addresses are five BCD digits (20 bits); fast register index is the low two digits
  localparam int          DIGIT_W       = 4;
  localparam int          ADDR_W        = 20;
  localparam int          SEL_W         = 8;
  localparam logic [11:0] FR_PREFIX     = 12'h999;
  localparam logic [7:0]  FR_INDEX_ZERO = 8'h00;
  localparam int          WORD_W        = 48;

  // Adder operand selects for the A address
  typedef enum logic [2:0] {
    FRICH_OFS_ZERO  = 3'b000,
    FRICH_OFS_ONE   = 3'b001,
    FRICH_OFS_TWO   = 3'b010,
    FRICH_OFS_THREE = 3'b011,
    FRICH_OFS_COND  = 3'b100
  } frich_ofs_t;

  // Decoded instruction control lines from the group encoder
  typedef struct packed {
    logic        aAddrGate;    // A field to adder
    logic        zeroSel;      // Zeros to adder
    logic [1:0]  dpOffset;     // +0..+3 for double precision
    logic        dpCond;       // Conditional +1 or 0 request
    logic        dpCondAdd;    // Value of the conditional add
    logic        aChainReq;    // A-input chain request
    logic        auInfoReq;    // Encoder information to AU
    logic        mChainDirect; // A operand routed through M chain
    logic        aDirectSel;   // A field straight to selector
    logic        adderSel;     // Adder to selector at t0
  } frich_ctl_t;

  // Strobes toward the fast register store and arithmetic unit
  typedef struct packed {
    logic        aFieldToAdder;
    logic        zerosToAdder;
    logic        adderToSelector;
    logic        encoderToAu;
    logic        frRegenerate;
    logic        frReadout;
    logic        parityCheckStart;
    logic        mLowDigitsToSelector;
    logic        aFieldDirectToSelector;
    logic        regenToMInput;
  } frich_strb_t;

  // BCD add of a small offset to a two-digit index, wrapping at 100
  function automatic logic [7:0] frich_bcd_add(input logic [7:0] idx, input logic [1:0] ofs);
    logic [3:0] lo;
    logic [3:0] hi;
    logic [4:0] sum;
    lo  = idx[3:0];
    hi  = idx[7:4];
    sum = {1'b0, lo} + {3'b000, ofs};
    if (sum > 5'h09) begin
      lo = 4'(sum - 5'h0A);
      hi = (hi == 4'h9) ? 4'h0 : 4'(hi + 4'h1);
    end else begin
      lo = sum[3:0];
    end
    return {hi, lo};
  endfunction

endpackage

//--- core/frich_phase_gen.sv
// Eight-phase pulse generator, one phase per PHASE_CLKS clocks
`timescale 1ns/1ns
module frich_phase_gen
  import frich_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  output logic [2:0]      phase,
  output logic            phaseStrobe
);

  logic [5:0] divCnt_reg;

  // Divider; the strobe marks the last clock of a phase so every phase acts once
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      divCnt_reg <= 6'h00;
    end else if (divCnt_reg == PHASE_LAST) begin
      divCnt_reg <= 6'h00;
    end else begin
      divCnt_reg <= divCnt_reg + 6'h01;
    end
  end

  // Phase counter wraps t7 to t0 every 4 us
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      phase <= PH_T0;
    end else if (divCnt_reg == PHASE_LAST) begin
      phase <= phase + 3'h1;
    end
  end

  assign phaseStrobe = (divCnt_reg == PHASE_LAST);

endmodule

//--- tb/frich_far_model.sv
// Fast register store model: one word per BCD index, destructive read, rewrite on regenerate
`timescale 1ns/1ns
module frich_far_model
  import frich_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic [SEL_W-1:0]  selector,
  input  wire frich_strb_t       strobe,
  input  wire logic [WORD_W-1:0] writeData,
  output logic [WORD_W-1:0]      readData
);
  logic [WORD_W-1:0] store [256];

  // Distinct word per register so a wrong selector shows up
  initial begin
    for (int i = 0; i < 256; i++) begin
      store[i] = {6{8'(i) ^ 8'h3C}};
    end
  end

  // Readout always sees the selected register
  assign readData = store[selector];

  // A core read wipes the word; only the regenerate strobe puts it back
  always @(posedge clk_sys) begin
    if (strobe.frRegenerate === 1'b1) begin
      store[selector] <= writeData;
    end else if (strobe.frReadout === 1'b1) begin
      store[selector] <= '0;
    end
  end
endmodule

//--- tb/test_frich_ctrl.sv
// Self-checking bench for the fast-register input chain controller
`timescale 1ns/1ns
module test_frich_ctrl;
  import frich_pkg::*;
  localparam int S_AFA = 9, S_ZTA = 8, S_ATS = 7, S_ETA = 6, S_RG = 5;
  localparam int S_RD = 4, S_PCS = 3, S_MLS = 2, S_ADS = 1, S_RTM = 0;
  localparam int TIMEOUT = 20000;
  logic              clk_sys, sys_rst, generalMemoryRead, memNotBusy, aConflict, mConflict;
  frich_ctl_t        ctl;
  frich_strb_t       strobe_reg;
  logic [ADDR_W-1:0] secondInstrA, secondInstrM, adderOut, adderInA_reg, adderInB_reg;
  logic [WORD_W-1:0] frReadData, aInput_reg, mInput_reg, frWriteData_reg;
  logic [SEL_W-1:0]  selector_reg;
  logic [2:0]        phase_reg;
  logic              operandAck_reg, aChainStart_reg, mChainStart_reg, frRead_reg;
  logic [9:0]        strobeBits;
  logic [2:0]        strobePh [10];
  int                strobeCnt [10];
  logic [3:0]        seenLvl;
  int                ph3Clks, cycleCount, err_count, samples_checked;

  assign strobeBits = strobe_reg;

  frich_ctrl frich_ctrl_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .ctl(ctl),
    .secondInstrA(secondInstrA), .secondInstrM(secondInstrM), .adderOut(adderOut),
    .generalMemoryRead(generalMemoryRead), .memNotBusy(memNotBusy), .aConflict(aConflict),
    .mConflict(mConflict), .frReadData(frReadData), .phase_reg(phase_reg),
    .strobe_reg(strobe_reg), .adderInA_reg(adderInA_reg), .adderInB_reg(adderInB_reg),
    .selector_reg(selector_reg), .aInput_reg(aInput_reg), .mInput_reg(mInput_reg),
    .frWriteData_reg(frWriteData_reg), .operandAck_reg(operandAck_reg),
    .aChainStart_reg(aChainStart_reg), .mChainStart_reg(mChainStart_reg),
    .frRead_reg(frRead_reg));

  frich_far_model frich_far_model_i (.clk_sys(clk_sys), .selector(selector_reg),
    .strobe(strobe_reg), .writeData(frWriteData_reg), .readData(frReadData));

  // Clock at 100 MHz
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Monitor: strobe counts, phase at last pulse, sticky levels; also the hang guard
  always @(posedge clk_sys) begin
    cycleCount = cycleCount + 1;
    if (cycleCount == TIMEOUT) begin
      err_count = err_count + 1;
      complete_run();
    end else if (!sys_rst) begin
      for (int b = 0; b < 10; b++) begin
        if (strobeBits[b] === 1'b1) begin
          strobeCnt[b] = strobeCnt[b] + 1;
          strobePh[b] = phase_reg;
        end
      end
      seenLvl = seenLvl | {aChainStart_reg, mChainStart_reg, frRead_reg, operandAck_reg};
      if (phase_reg === PH_T3) ph3Clks = ph3Clks + 1;
    end
  end

  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (err_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [47:0] word(input logic [7:0] idx);
    return {6{idx ^ 8'h3C}};
  endfunction

  // Strobe must have pulsed, last time in the given phase
  task automatic strb(input string name, input int idx, input logic [2:0] expPh);
    check(name, {44'h0, strobeCnt[idx] > 0, strobePh[idx]}, {44'h0, 1'b1, expPh});
  endtask

  task automatic nostrb(input string name, input int idx);
    check(name, 48'(strobeCnt[idx]), 48'h0);
  endtask

  task automatic idle();
    ctl = '0;
    {secondInstrA, secondInstrM, adderOut} = '0;
    {generalMemoryRead, memNotBusy, aConflict, mConflict} = 4'h0;
  endtask

  // Reset for six clocks, check cleared outputs, then run two full phase cycles
  task automatic run_test();
    sys_rst = 1'b1;
    repeat (6) @(negedge clk_sys);
    check("rst_ctl", 48'({phase_reg, strobe_reg, selector_reg, operandAck_reg,
          aChainStart_reg, mChainStart_reg, frRead_reg}), 48'h0);
    check("rst_data", aInput_reg | mInput_reg | frWriteData_reg, 48'h0);
    sys_rst = 1'b0;
    for (int b = 0; b < 10; b++) begin
      strobeCnt[b] = 0;
      strobePh[b] = 'x;
    end
    seenLvl = 4'h0;
    ph3Clks = 0;
    repeat (810) @(negedge clk_sys);
  endtask

  // Main sequence, inputs change at the falling edge only
  initial begin
    {cycleCount, err_count, samples_checked} = '0;
    sys_rst = 1'b1;
    idle();
    // A-input chain, no conflict
    ctl.aAddrGate = 1'b1;
    ctl.zeroSel = 1'b1;
    ctl.aChainReq = 1'b1;
    ctl.auInfoReq = 1'b1;
    memNotBusy = 1'b1;
    secondInstrA = 20'h00012;
    adderOut = 20'h00012;
    run_test();
    check("ph3_clks", 48'(ph3Clks), 48'(2 * PHASE_CLKS));
    check("afa_count", 48'(strobeCnt[S_AFA]), 48'h2);
    strb("a_to_adder", S_AFA, PH_T2);
    check("adder_a", 48'(adderInA_reg), 48'(secondInstrA));
    strb("zero_to_adder", S_ZTA, PH_T2);
    check("adder_b", 48'(adderInB_reg), 48'h0);
    check("a_start", 48'(seenLvl[3]), 48'h1);
    strb("adder_to_sel", S_ATS, PH_T4);
    check("sel_a", 48'(selector_reg), 48'h12);
    strb("enc_to_au", S_ETA, PH_T5);
    strb("a_readout", S_RD, PH_T7);
    strb("a_regen", S_RG, PH_T7);
    check("a_reads", 48'(strobeCnt[S_RD]), 48'h2);
    check("a_input", aInput_reg, word(8'h12));
    check("fr_write", frWriteData_reg, word(8'h12));
    strb("a_parity", S_PCS, PH_T0);
    // Same with a register conflict: regenerate only
    aConflict = 1'b1;
    run_test();
    nostrb("conf_readout", S_RD);
    strb("conf_regen", S_RG, PH_T7);
    nostrb("conf_parity", S_PCS);
    // Request without acknowledge starts nothing
    idle();
    ctl.aChainReq = 1'b1;
    ctl.auInfoReq = 1'b1;
    run_test();
    check("noack_start", 48'(seenLvl[3]), 48'h0);
    nostrb("noack_sel", S_ATS);
    nostrb("noack_enc", S_ETA);
    // Double precision offsets and conditional add
    for (int k = 0; k < 5; k++) begin
      idle();
      ctl.aAddrGate = 1'b1;
      ctl.dpOffset = (k < 3) ? 2'(k + 1) : 2'h0;
      ctl.dpCond = (k >= 3);
      ctl.dpCondAdd = (k == 4);
      run_test();
      check("dp_b", 48'(adderInB_reg), (k < 3) ? 48'(k + 1) : 48'(k - 3));
      check("dp_start", 48'(seenLvl[3]), 48'(k >= 3));
    end
    // M address in the fast register range, with and without conflict
    for (int c = 0; c < 2; c++) begin
      idle();
      generalMemoryRead = 1'b1;
      adderOut = 20'h99907;
      secondInstrM = 20'h99907;
      mConflict = 1'(c);
      run_test();
      check("fr_read", 48'(seenLvl[1]), 48'h1);
      check("sim_ack", 48'(seenLvl[0]), 48'h1);
      check("m_start", 48'(seenLvl[2]), 48'h1);
      strb("m_low_sel", S_MLS, PH_T0);
      check("sel_m", 48'(selector_reg), 48'h07);
      strb("m_regen", S_RG, PH_T3);
      strb("m_readout", S_RD, PH_T3);
      if (c == 0) begin
        strb("m_transfer", S_RTM, PH_T4);
        check("m_input", mInput_reg, word(8'h07));
        strb("m_parity", S_PCS, PH_T4);
      end else begin
        nostrb("m_conf_xfer", S_RTM);
        nostrb("m_conf_par", S_PCS);
      end
    end
    // Outside the range, or not a memory read: no fast register reference
    for (int n = 0; n < 2; n++) begin
      idle();
      generalMemoryRead = (n == 1) ? 1'b0 : 1'b1;
      adderOut = (n == 1) ? 20'h99907 : 20'h99807;
      run_test();
      check("no_fr_read", 48'(seenLvl[1]), 48'h0);
      nostrb("no_m_sel", S_MLS);
    end
    // A operand through the M chain: direct A field, then adder output at t0
    for (int j = 0; j < 2; j++) begin
      idle();
      ctl.mChainDirect = 1'b1;
      ctl.aDirectSel = (j == 0);
      ctl.adderSel = (j == 1);
      memNotBusy = 1'b1;
      secondInstrA = 20'h00045;
      adderOut = 20'h00033;
      run_test();
      check("direct_m_start", 48'(seenLvl[2]), 48'h1);
      strb("t0_sel", (j == 0) ? S_ADS : S_ATS, PH_T0);
      check("sel_direct", 48'(selector_reg), (j == 0) ? 48'h45 : 48'h33);
      check("m_direct_in", mInput_reg, word((j == 0) ? 8'h45 : 8'h33));
    end
    complete_run();
  end
endmodule
